// File: sync_reg_pkg.sv
// Constants and types for the genset synchronization regulator
//
// Behaviour
// - Synchronized output active only while synchronizing and closure enable is set.
// - Voltage and frequency are both regulated through commands sent over CAN.
// - Regulation commands go on CAN only while a synchronization runs.
// - External synchronizer analogue command is forwarded over CAN as speed command.
// - Only 0-10 Vdc level commands accepted; no PWM or up/down pulses.
// - Any input sub-range maps to frequency change, optionally inverted.
// - Function selector: mains only, group only, or both breakers externally.
// - Analogue input scaled between minimum and maximum settings in percent.
// - Speed command percent: 0 is nominal minus 4 Hz, 100 nominal plus 4 Hz.
// - Scaled voltage converted to percent through a two-point linked curve.
// - During external synchronization the frequency command follows the converted input.
// - Voltage command never from external synchronizer; always internal regulator.
// - Two external inputs, each with its own selector and curve; input 0 wins when both serve a breaker.
// - Internal speed PI uses phase difference as error input.
// - Two PI regulators, speed and voltage, each with own gain and integral.
// - Voltage gain and integral both zero means no voltage regulation.
// - Integral term accumulates error and is added to proportional term.
// - PI parameters may change while running, applied without restart.
// - Closure enable only after all checks pass for the confirmation time.
// - After withdrawal, closure enable stays off at least one second.
package sync_reg_pkg;

  // ----------------------------------------------------------------
  // Widths and ranges
  // ----------------------------------------------------------------
  localparam int unsigned ADC_W       = 12;      // Input code, 0..4095 is 0..10 V
  localparam int unsigned PCT_W       = 10;      // Percent in tenths, 0..1000
  localparam int unsigned ERR_W       = 16;      // Signed regulator error
  localparam int unsigned GAIN_W      = 16;      // Gains, 8 fraction bits
  localparam int unsigned GAIN_FRAC   = 8;
  localparam int unsigned ACC_W       = 32;
  localparam logic [PCT_W-1:0] PCT_MAX = 10'h3E8; // 100.0 %
  localparam logic [PCT_W-1:0] PCT_MID = 10'h1F4; // 50.0 %, nominal
  localparam logic [ADC_W-1:0] ADC_MAX = 12'hFFF; // 10 V full span
  localparam int unsigned SPAN_VDC    = 10;
  localparam int unsigned SPEED_SPAN_HZ = 4;     // 0 % / 100 % = -/+ 4 Hz

  // ----------------------------------------------------------------
  // Analogue input function selector codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_NONE                     = 2'b00,
    FN_EXT_SYNC_MAINS_BREAKER_ONLY = 2'b01,
    FN_EXT_SYNC_GROUP_BREAKER_ONLY = 2'b10,
    FN_EXT_SYNC_BOTH_BREAKERS   = 2'b11
  } ain_func_t;

  // Breaker being synchronized
  typedef enum logic {
    BRK_MAINS = 1'b0,
    BRK_GROUP = 1'b1
  } breaker_t;

  // Closure enable state machine
  typedef enum logic [1:0] {
    CE_IDLE    = 2'b00,
    CE_CONFIRM = 2'b01,
    CE_ENABLED = 2'b10,
    CE_HOLDOFF = 2'b11
  } ce_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned SAMPLE_US      = 1000;  // PI sampling interval
  localparam int unsigned SAMPLE_CYCLES  = SAMPLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HOLDOFF_MS     = 1000;  // One second
  localparam int unsigned HOLDOFF_CYCLES = HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W          = 32;

endpackage : sync_reg_pkg

// File: genset_sync_regulator.sv
// Synchronization regulator: PI loops, external synchronizer path, closure enable
module genset_sync_regulator #(
  parameter int unsigned SAMPLE_CYC  = sync_reg_pkg::SAMPLE_CYCLES,
  parameter int unsigned HOLDOFF_CYC = sync_reg_pkg::HOLDOFF_CYCLES
) (
  // Clock and reset
  input  wire logic                              i_mclk,
  input  wire logic                              i_reset,
  // Synchronization control
  input  wire logic                              i_sync_active,
  input  wire sync_reg_pkg::breaker_t            i_breaker_sel,
  input  wire logic                              i_checks_ok,
  input  wire logic [sync_reg_pkg::CNT_W-1:0]    i_confirm_cycles,
  // Analogue input function selectors, one per input
  input  wire sync_reg_pkg::ain_func_t           i_ain0_func,
  input  wire sync_reg_pkg::ain_func_t           i_ain1_func,
  // Analogue input samples and scaling
  input  wire logic [sync_reg_pkg::ADC_W-1:0]    i_ain0_code,
  input  wire logic [sync_reg_pkg::ADC_W-1:0]    i_ain1_code,
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_ain0_min_pct,
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_ain0_max_pct,
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_ain1_min_pct,
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_ain1_max_pct,
  // Conversion curves: percent out at scaled 0 % and at scaled 100 %
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_curve0_lo_pct,
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_curve0_hi_pct,
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_curve1_lo_pct,
  input  wire logic [sync_reg_pkg::PCT_W-1:0]    i_curve1_hi_pct,
  // Regulation errors and gains
  input  wire logic signed [sync_reg_pkg::ERR_W-1:0] i_phase_err,
  input  wire logic signed [sync_reg_pkg::ERR_W-1:0] i_volt_err,
  input  wire logic [sync_reg_pkg::GAIN_W-1:0]   i_spd_kp,
  input  wire logic [sync_reg_pkg::GAIN_W-1:0]   i_spd_ki,
  input  wire logic [sync_reg_pkg::GAIN_W-1:0]   i_vlt_kp,
  input  wire logic [sync_reg_pkg::GAIN_W-1:0]   i_vlt_ki,
  // CAN command side
  output logic                                   o_cmd_valid,
  output logic [sync_reg_pkg::PCT_W-1:0]         o_speed_cmd_pct,
  output logic                                   o_volt_cmd_valid,
  output logic [sync_reg_pkg::PCT_W-1:0]         o_volt_cmd_pct,
  // Status
  output logic                                   o_closure_enable,
  output logic                                   o_synchronized_indication_output
);
  import sync_reg_pkg::*;

  localparam int unsigned SUM_W = ERR_W + GAIN_W + 2;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Scaled position of a code inside the min..max window, in tenths of percent
  function automatic logic [PCT_W-1:0] scale_in(
    input logic [ADC_W-1:0] code,
    input logic [PCT_W-1:0] mn,
    input logic [PCT_W-1:0] mx
  );
    logic [PCT_W+ADC_W:0] in_pct;
    logic [PCT_W+ADC_W:0] num;
    logic [PCT_W-1:0]     span;
    in_pct = (PCT_W + ADC_W + 1)'((32'(code) * 32'(PCT_MAX)) / 32'(ADC_MAX));
    span   = (mx > mn) ? (mx - mn) : {{(PCT_W-1){1'b0}}, 1'b1};
    if (in_pct <= (PCT_W + ADC_W + 1)'(mn)) begin
      scale_in = '0;
    end else if (in_pct >= (PCT_W + ADC_W + 1)'(mx)) begin
      scale_in = PCT_MAX;
    end else begin
      num      = (in_pct - (PCT_W + ADC_W + 1)'(mn)) * (PCT_W + ADC_W + 1)'(PCT_MAX);
      scale_in = PCT_W'(num / (PCT_W + ADC_W + 1)'(span));
    end
  endfunction : scale_in

  // Two-point curve, lo may exceed hi for an inverted mapping
  function automatic logic [PCT_W-1:0] curve(
    input logic [PCT_W-1:0] x,
    input logic [PCT_W-1:0] lo,
    input logic [PCT_W-1:0] hi
  );
    logic signed [2*PCT_W+2:0] d;
    logic signed [2*PCT_W+2:0] y;
    d = $signed({3'b000, hi}) - $signed({3'b000, lo});
    y = $signed({3'b000, lo}) + (d * $signed({{(PCT_W+3){1'b0}}, x})) / $signed((2*PCT_W+3)'(PCT_MAX));
    if (y < 0) begin
      curve = '0;
    end else if (y > $signed((2*PCT_W+3)'(PCT_MAX))) begin
      curve = PCT_MAX;
    end else begin
      curve = PCT_W'(y);
    end
  endfunction : curve

  // Clamp a signed offset around midpoint into 0..100 %
  function automatic logic [PCT_W-1:0] clamp_pct(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] s;
    s = v + $signed(ACC_W'(PCT_MID));
    if (s < 0) begin
      clamp_pct = '0;
    end else if (s > $signed(ACC_W'(PCT_MAX))) begin
      clamp_pct = PCT_MAX;
    end else begin
      clamp_pct = PCT_W'(s);
    end
  endfunction : clamp_pct

  // True when an input serves the given breaker externally
  function automatic logic serves(input ain_func_t f, input breaker_t b);
    serves = (f == FN_EXT_SYNC_BOTH_BREAKERS) ||
             (f == FN_EXT_SYNC_MAINS_BREAKER_ONLY && b == BRK_MAINS) ||
             (f == FN_EXT_SYNC_GROUP_BREAKER_ONLY && b == BRK_GROUP);
  endfunction : serves

  // ----------------------------------------------------------------
  // External synchronizer path
  // ----------------------------------------------------------------
  // Each input keeps its own curve; input 0 wins when both claim a breaker
  logic             use_ext0;
  logic             use_ext1;
  logic             use_ext;
  logic [PCT_W-1:0] ext0_pct;
  logic [PCT_W-1:0] ext1_pct;
  logic [PCT_W-1:0] ext_pct;

  assign use_ext0 = serves(i_ain0_func, i_breaker_sel);
  assign use_ext1 = serves(i_ain1_func, i_breaker_sel);
  assign use_ext  = use_ext0 || use_ext1;
  // Plain level inputs only; the code is a 0-10 V DC reading
  assign ext0_pct = curve(scale_in(i_ain0_code, i_ain0_min_pct, i_ain0_max_pct),
                          i_curve0_lo_pct, i_curve0_hi_pct);
  assign ext1_pct = curve(scale_in(i_ain1_code, i_ain1_min_pct, i_ain1_max_pct),
                          i_curve1_lo_pct, i_curve1_hi_pct);
  assign ext_pct  = use_ext0 ? ext0_pct : ext1_pct;

  // ----------------------------------------------------------------
  // Sample interval divider
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] samp_cnt_q;
  logic             samp_tick;

  assign samp_tick = (samp_cnt_q == CNT_W'(SAMPLE_CYC - 1));

  // Fixed rate keeps integral gain independent of clock speed
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      samp_cnt_q <= '0;
    end else if (samp_tick || !i_sync_active) begin
      samp_cnt_q <= '0;
    end else begin
      samp_cnt_q <= samp_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // PI regulators
  // ----------------------------------------------------------------
  logic                     sync_q;
  logic                     sync_start;
  logic signed [ACC_W-1:0]  spd_acc_q;
  logic signed [ACC_W-1:0]  vlt_acc_q;
  logic signed [SUM_W-1:0]  spd_p;
  logic signed [SUM_W-1:0]  spd_i;
  logic signed [SUM_W-1:0]  vlt_p;
  logic signed [SUM_W-1:0]  vlt_i;
  logic signed [ACC_W-1:0]  spd_out;
  logic signed [ACC_W-1:0]  vlt_out;
  logic                     vlt_enabled;

  assign sync_start  = i_sync_active && !sync_q;
  // Gains are read live every sample, so edits apply at once
  assign spd_p = i_phase_err * $signed({1'b0, i_spd_kp});
  assign spd_i = i_phase_err * $signed({1'b0, i_spd_ki});
  assign vlt_p = i_volt_err  * $signed({1'b0, i_vlt_kp});
  assign vlt_i = i_volt_err  * $signed({1'b0, i_vlt_ki});
  assign spd_out = ACC_W'((SUM_W'(spd_p) + SUM_W'(spd_acc_q)) >>> GAIN_FRAC);
  assign vlt_out = ACC_W'((SUM_W'(vlt_p) + SUM_W'(vlt_acc_q)) >>> GAIN_FRAC);
  assign vlt_enabled = (i_vlt_kp != '0) || (i_vlt_ki != '0);

  // Sync start edge detector
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sync_q <= 1'b0;
    end else begin
      sync_q <= i_sync_active;
    end
  end

  // Integral accumulators; no anti-windup beyond the final clamp
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      spd_acc_q <= '0;
      vlt_acc_q <= '0;
    end else if (sync_start) begin
      spd_acc_q <= '0;
      vlt_acc_q <= '0;
    end else if (i_sync_active && samp_tick) begin
      spd_acc_q <= spd_acc_q + ACC_W'(spd_i);
      vlt_acc_q <= vlt_acc_q + ACC_W'(vlt_i);
    end
  end

  // ----------------------------------------------------------------
  // CAN command outputs
  // ----------------------------------------------------------------
  // Commands refresh each sample and are withdrawn outside a synchronization
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_cmd_valid      <= 1'b0;
      o_speed_cmd_pct  <= PCT_MID;
      o_volt_cmd_valid <= 1'b0;
      o_volt_cmd_pct   <= PCT_MID;
    end else if (!i_sync_active) begin
      o_cmd_valid      <= 1'b0;
      o_volt_cmd_valid <= 1'b0;
      o_speed_cmd_pct  <= PCT_MID;
      o_volt_cmd_pct   <= PCT_MID;
    end else if (samp_tick) begin
      o_cmd_valid      <= 1'b1;
      o_volt_cmd_valid <= vlt_enabled;
      // Percent maps 0..100 onto nominal -4..+4 Hz at the genset end
      o_speed_cmd_pct  <= use_ext ? ext_pct : clamp_pct(spd_out);
      // Never from the external synchronizer
      o_volt_cmd_pct   <= vlt_enabled ? clamp_pct(vlt_out) : PCT_MID;
    end
  end

  // ----------------------------------------------------------------
  // Closure enable
  // ----------------------------------------------------------------
  ce_state_t        ce_q;
  logic [CNT_W-1:0] ce_cnt_q;

  // Confirm checks continuously, then hold off after any withdrawal
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ce_q     <= CE_IDLE;
      ce_cnt_q <= '0;
    end else begin
      case (ce_q)
        CE_IDLE: begin
          ce_cnt_q <= '0;
          if (i_checks_ok) begin
            ce_q <= CE_CONFIRM;
          end
        end
        CE_CONFIRM: begin
          if (!i_checks_ok) begin
            ce_q     <= CE_IDLE;
            ce_cnt_q <= '0;
          end else if (ce_cnt_q >= i_confirm_cycles) begin
            ce_q     <= CE_ENABLED;
            ce_cnt_q <= '0;
          end else begin
            ce_cnt_q <= ce_cnt_q + 1'b1;
          end
        end
        CE_ENABLED: begin
          ce_cnt_q <= '0;
          if (!i_checks_ok) begin
            ce_q <= CE_HOLDOFF;
          end
        end
        CE_HOLDOFF: begin
          if (ce_cnt_q >= CNT_W'(HOLDOFF_CYC - 1)) begin
            ce_q     <= CE_IDLE;
            ce_cnt_q <= '0;
          end else begin
            ce_cnt_q <= ce_cnt_q + 1'b1;
          end
        end
        default: begin
          ce_q <= CE_IDLE;
        end
      endcase
    end
  end

  // Registered status outputs
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_closure_enable                 <= 1'b0;
      o_synchronized_indication_output <= 1'b0;
    end else begin
      o_closure_enable                 <= (ce_q == CE_ENABLED) && i_checks_ok;
      o_synchronized_indication_output <= (ce_q == CE_ENABLED) && i_checks_ok && i_sync_active;
    end
  end

endmodule : genset_sync_regulator

// File: sync_reg_asserts.sv
// Port-level checker for the synchronization regulator
module sync_reg_asserts #(
  parameter int unsigned HOLDOFF_CYC = 20
) (
  // Clock and reset
  input wire logic                           i_mclk,
  input wire logic                           i_reset,
  // Watched inputs
  input wire logic                           i_sync_active,
  input wire logic                           i_checks_ok,
  input wire logic [sync_reg_pkg::CNT_W-1:0] i_confirm_cycles,
  input wire logic [sync_reg_pkg::GAIN_W-1:0] i_vlt_kp,
  input wire logic [sync_reg_pkg::GAIN_W-1:0] i_vlt_ki,
  // Watched outputs
  input wire logic                           o_cmd_valid,
  input wire logic [sync_reg_pkg::PCT_W-1:0] o_speed_cmd_pct,
  input wire logic                           o_volt_cmd_valid,
  input wire logic [sync_reg_pkg::PCT_W-1:0] o_volt_cmd_pct,
  input wire logic                           o_closure_enable,
  input wire logic                           o_synchronized_indication_output
);
  timeunit 1ns;
  timeprecision 100ps;
  import sync_reg_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic [31:0] off_q;
  logic [31:0] ok_q;
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  // Off time saturates and starts full, so the first grant after reset is not held back
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) off_q <= HOLDOFF_CYC;
    else if (o_closure_enable) off_q <= '0;
    else if (off_q < HOLDOFF_CYC) off_q <= off_q + 32'h1;
  end
  // Consecutive cycles with all checks passing
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) ok_q <= '0;
    else if (!i_checks_ok) ok_q <= '0;
    else if (ok_q != 32'hFFFFFFFF) ok_q <= ok_q + 32'h1;
  end
  // ----------------------------------------
  // Sync start steps, command and closure properties
  // ----------------------------------------
  sequence s_start;
    $rose(i_sync_active);
  endsequence
  sequence s_first_cmd;
    !o_cmd_valid ##1 !o_cmd_valid ##[1:40] o_cmd_valid;
  endsequence
  chk_first_tick: assert property (s_start |-> s_first_cmd)
    else $error("no command within bound after sync start");
  chk_cmd_in_sync: assert property (o_cmd_valid |-> $past(i_sync_active))
    else $error("speed command outside synchronization");
  chk_idle_nominal: assert property (!$past(i_sync_active) |-> !o_volt_cmd_valid && o_speed_cmd_pct == PCT_MID)
    else $error("idle outputs not at nominal");
  chk_volt_pairs: assert property (o_volt_cmd_valid |-> o_cmd_valid)
    else $error("voltage command without speed command");
  chk_volt_gains: assert property ($rose(o_volt_cmd_valid) |-> $past(i_vlt_kp) != 0 || $past(i_vlt_ki) != 0)
    else $error("voltage command with zero gains");
  chk_pct_range: assert property (o_speed_cmd_pct <= PCT_MAX && o_volt_cmd_pct <= PCT_MAX)
    else $error("command above full range");
  chk_ind_sync: assert property (o_synchronized_indication_output |-> $past(i_sync_active))
    else $error("indication outside synchronization");
  chk_ind_rise: assert property ((o_closure_enable && i_sync_active) [*3] |-> o_synchronized_indication_output)
    else $error("indication missing while enabled");
  chk_confirm_time: assert property ($rose(o_closure_enable) |-> ok_q >= i_confirm_cycles)
    else $error("closure enabled before confirmation time");
  chk_ok_drop: assert property ($fell(i_checks_ok) |-> ##[1:2] !o_closure_enable)
    else $error("closure kept after checks failed");
  chk_holdoff_min: assert property ($rose(o_closure_enable) |-> off_q >= HOLDOFF_CYC)
    else $error("closure re-enabled inside holdoff");
endmodule : sync_reg_asserts

bind genset_sync_regulator sync_reg_asserts #(.HOLDOFF_CYC(HOLDOFF_CYC)) chk_u (.i_mclk, .i_reset,
  .i_sync_active, .i_checks_ok, .i_confirm_cycles, .i_vlt_kp, .i_vlt_ki, .o_cmd_valid, .o_speed_cmd_pct,
  .o_volt_cmd_valid, .o_volt_cmd_pct, .o_closure_enable, .o_synchronized_indication_output);

// File: genset_ctrl_model.sv
// Genset controller model: takes set-points arriving over the CAN side
module genset_ctrl_model (
  // Clock and reset
  input wire logic                           i_mclk,
  input wire logic                           i_reset,
  // Commands from the regulator
  input wire logic                           i_cmd_valid,
  input wire logic                           i_volt_valid,
  input wire logic [sync_reg_pkg::PCT_W-1:0] i_speed_pct,
  input wire logic [sync_reg_pkg::PCT_W-1:0] i_volt_pct,
  // Set-points in use
  output logic [sync_reg_pkg::PCT_W-1:0]     o_speed_sp,
  output logic [sync_reg_pkg::PCT_W-1:0]     o_volt_sp,
  output int                                 o_rx_count
);
  timeunit 1ns;
  timeprecision 100ps;
  import sync_reg_pkg::*;
  // No supervision gate: every valid command is taken, as a real unit would
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_speed_sp <= PCT_MID;
      o_volt_sp  <= PCT_MID;
      o_rx_count <= 0;
    end else begin
      if (i_cmd_valid) o_speed_sp <= i_speed_pct;
      if (i_volt_valid) o_volt_sp <= i_volt_pct;
      if (i_cmd_valid) o_rx_count <= o_rx_count + 1;
    end
  end
endmodule : genset_ctrl_model

// File: tb_top.sv
// Self-checking bench for the synchronization regulator
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sync_reg_pkg::*;
  localparam int SC = 10;
  localparam int HC = 20;
  logic i_mclk = 0, i_reset = 1, i_sync_active = 0, i_checks_ok = 0;
  breaker_t i_breaker_sel = BRK_MAINS;
  logic [CNT_W-1:0] i_confirm_cycles = 32'h3;
  ain_func_t i_ain0_func = FN_NONE, i_ain1_func = FN_NONE;
  logic [ADC_W-1:0] i_ain0_code = '0, i_ain1_code = '0;
  logic [PCT_W-1:0] i_ain0_min_pct = '0, i_ain0_max_pct = PCT_MAX, i_ain1_min_pct = '0, i_ain1_max_pct = PCT_MAX;
  logic [PCT_W-1:0] i_curve0_lo_pct = '0, i_curve0_hi_pct = '0, i_curve1_lo_pct = '0, i_curve1_hi_pct = '0;
  logic signed [ERR_W-1:0] i_phase_err = '0, i_volt_err = '0;
  logic [GAIN_W-1:0] i_spd_kp = '0, i_spd_ki = '0, i_vlt_kp = '0, i_vlt_ki = '0;
  logic o_cmd_valid, o_volt_cmd_valid, o_closure_enable, o_synchronized_indication_output;
  logic [PCT_W-1:0] o_speed_cmd_pct, o_volt_cmd_pct, sp_seen, vp_seen, lo, hi, a, b;
  int rx_count, err_total = 0, n_compared = 0, pe, ve;
  logic [31:0] rnd = 32'h3919529D;
  logic top, serves;

  genset_sync_regulator #(.SAMPLE_CYC(SC), .HOLDOFF_CYC(HC)) dut_u (.i_mclk, .i_reset, .i_sync_active,
    .i_breaker_sel, .i_checks_ok, .i_confirm_cycles, .i_ain0_func, .i_ain1_func, .i_ain0_code, .i_ain1_code,
    .i_ain0_min_pct, .i_ain0_max_pct, .i_ain1_min_pct, .i_ain1_max_pct, .i_curve0_lo_pct, .i_curve0_hi_pct,
    .i_curve1_lo_pct, .i_curve1_hi_pct, .i_phase_err, .i_volt_err, .i_spd_kp, .i_spd_ki, .i_vlt_kp, .i_vlt_ki,
    .o_cmd_valid, .o_speed_cmd_pct, .o_volt_cmd_valid, .o_volt_cmd_pct, .o_closure_enable,
    .o_synchronized_indication_output);
  genset_ctrl_model far_u (.i_mclk, .i_reset, .i_cmd_valid(o_cmd_valid), .i_volt_valid(o_volt_cmd_valid),
    .i_speed_pct(o_speed_cmd_pct), .i_volt_pct(o_volt_cmd_pct), .o_speed_sp(sp_seen), .o_volt_sp(vp_seen),
    .o_rx_count(rx_count));

  // Free-running 100 MHz clock
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Proportional-only path at unity gain, clamped to the command span
  function automatic logic [PCT_W-1:0] pi_exp(input int e);
    return (500 + e > 1000) ? PCT_MAX : (500 + e < 0) ? '0 : PCT_W'(500 + e);
  endfunction : pi_exp
  // Window scaling then two-point curve; only meaningful inside the window
  function automatic int ext_exp(input int code, input int mn, input int mx, input int lo, input int hi);
    int s;
    s = (code * int'(PCT_MAX) / int'(ADC_MAX) - mn) * int'(PCT_MAX) / (mx - mn);
    return lo + (hi - lo) * s / int'(PCT_MAX);
  endfunction : ext_exp
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s seen %0h want %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // Settle one or more edges, then sample
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc
  // Raise sync and wait, bounded, for the first tick to reach the far side
  task automatic start_sync();
    @(posedge i_mclk) i_sync_active <= 1'b1;
    for (int k = 0; k < 60 && o_cmd_valid !== 1'b1; k++) cyc(1);
    if (o_cmd_valid !== 1'b1) begin
      check(0, 1, "no command tick");
      tally_and_finish();
    end
    cyc(1);
  endtask : start_sync
  task automatic stop_sync();
    @(posedge i_mclk) i_sync_active <= 1'b0;
    cyc(3);
    check(o_cmd_valid, 0, "valid after sync");
    check(o_speed_cmd_pct, PCT_MID, "idle speed");
  endtask : stop_sync

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge i_mclk);
    i_reset <= 1'b0;
    cyc(1);
    check(o_cmd_valid, 0, "reset valid");
    // Each external selector code (not FN_NONE) on each input and breaker; curve ends hit exactly at span edges
    for (int f = 1; f < 4; f++) for (int br = 0; br < 2; br++) for (int n = 0; n < 2; n++) begin
      rnd = lfsr(rnd);
      lo = rnd[9:0] % 10'd1001;
      hi = rnd[25:16] % 10'd1001;
      top = rnd[31];
      pe = int'(signed'(rnd[7:0]));
      ve = int'(signed'(rnd[15:12]));
      serves = (f == 3) || (f == 1 && br == 0) || (f == 2 && br == 1);
      @(posedge i_mclk);
      i_breaker_sel <= breaker_t'(br);
      i_ain0_func <= (n == 0) ? ain_func_t'(f) : FN_NONE;
      i_ain1_func <= (n == 1) ? ain_func_t'(f) : FN_NONE;
      i_ain0_code <= top ? ADC_MAX : '0;
      i_ain1_code <= top ? ADC_MAX : '0;
      i_ain0_min_pct <= rnd[28] ? 10'h12C : '0;
      i_ain0_max_pct <= rnd[28] ? 10'h258 : PCT_MAX;
      {i_curve0_lo_pct, i_curve0_hi_pct} <= (n == 0) ? {lo, hi} : {hi, lo};
      {i_curve1_lo_pct, i_curve1_hi_pct} <= (n == 1) ? {lo, hi} : {hi, lo};
      {i_spd_kp, i_spd_ki, i_vlt_kp, i_vlt_ki} <= {16'h0100, 16'h0000, 16'h0100, 16'h0000};
      i_phase_err <= ERR_W'(pe);
      i_volt_err <= ERR_W'(ve);
      start_sync();
      check(sp_seen, serves ? (top ? hi : lo) : pi_exp(pe), "speed set-point");
      check(vp_seen, pi_exp(ve), "voltage set-point");
      check(o_synchronized_indication_output, 0, "indication without enable");
      stop_sync();
    end
    // Interior of a narrowed window; both inputs claim the breaker, input 0 must win
    rnd = lfsr(rnd);
    @(posedge i_mclk);
    {i_ain0_func, i_ain1_func} <= {FN_EXT_SYNC_BOTH_BREAKERS, FN_EXT_SYNC_BOTH_BREAKERS};
    i_ain0_code <= 12'h4CD + ADC_W'(rnd[9:0]);
    {i_ain0_min_pct, i_ain0_max_pct} <= {10'h12C, 10'h258};
    {i_curve0_lo_pct, i_curve0_hi_pct} <= {lo, hi};
    start_sync();
    check(sp_seen, ext_exp(12'h4CD + rnd[9:0], 10'h12C, 10'h258, lo, hi), "scaled interior");
    stop_sync();
    // Integral growth, live gain change, then clearing on restart
    @(posedge i_mclk);
    {i_ain0_func, i_ain1_func} <= {FN_NONE, FN_NONE};
    {i_spd_kp, i_spd_ki, i_vlt_kp, i_vlt_ki} <= {16'h0000, 16'h0100, 16'h0000, 16'h0000};
    i_phase_err <= 16'h0005;
    start_sync();
    check(o_volt_cmd_valid, 0, "voltage with zero gains");
    a = sp_seen;
    cyc(SC);
    check(sp_seen, a + 10'h005, "integral step");
    @(posedge i_mclk) i_spd_ki <= 16'h0200;
    cyc(SC - 1);
    b = sp_seen;
    cyc(SC);
    check(sp_seen, b + 10'h00A, "new integral gain");
    // Checks are held failing while gains are tuned, so closure must stay off
    check(o_closure_enable, 0, "closure while tuning");
    stop_sync();
    @(posedge i_mclk) i_spd_ki <= 16'h0100;
    start_sync();
    check(sp_seen, a, "first tick after restart");
    stop_sync();
    // Clamp at both ends of the span
    for (int i = 0; i < 2; i++) begin
      pe = i ? -2000 : 2000;
      @(posedge i_mclk);
      {i_spd_kp, i_spd_ki} <= {16'h0100, 16'h0000};
      i_phase_err <= ERR_W'(pe);
      start_sync();
      check(sp_seen, pi_exp(pe), "clamped speed");
      stop_sync();
    end
    // Closure enable, indication and holdoff
    rnd = lfsr(rnd);
    @(posedge i_mclk);
    i_confirm_cycles <= 32'(rnd[2:0]) + 32'h2;
    {i_sync_active, i_checks_ok} <= 2'b11;
    for (int k = 0; k < 40 && o_closure_enable !== 1'b1; k++) cyc(1);
    check(o_closure_enable, 1, "closure after confirm");
    cyc(3);
    check(o_synchronized_indication_output, 1, "indication while enabled");
    @(posedge i_mclk) i_sync_active <= 1'b0;
    cyc(3);
    check(o_synchronized_indication_output, 0, "indication after sync");
    @(posedge i_mclk) i_checks_ok <= 1'b0;
    @(posedge i_mclk) i_checks_ok <= 1'b1;
    cyc(1);
    check(o_closure_enable, 0, "closure after check loss");
    cyc(HC - 4);
    check(o_closure_enable, 0, "closure in holdoff");
    for (int k = 0; k < 60 && o_closure_enable !== 1'b1; k++) cyc(1);
    check(o_closure_enable, 1, "closure after holdoff");
    check(rx_count > 0, 1, "far side took commands");
    tally_and_finish();
  end
endmodule : tb_top
